/* File: rtcdr_top.sv */
`timescale 1ns/1ps
// Overview of operation
// - year tens digit, bcd 0-9, bits 7..4 of year register.
// - year ones digit, bcd 0-9, bits 3..0 of year register.
// - year register bits 15..8 read zero, no storage.
// - year writes ignored unless the write enable bit is one.
// - month tens digit is one bit at position 12.
// - month ones digit, bcd 0-9, bits 11..8.
// - day tens digit, two bits 0-3, bits 5..4.
// - day ones digit, bcd 0-9, bits 3..0.
// - month/day bits 15..13 and 7..6 read zero.
// - month/day writes taken only while write enable is one.
// - calendar logic advances year and month/day digits itself.
module rtcdr_top (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        srst,
  // register port
  input  wire logic [3:0]  addr,
  input  wire logic [15:0] wdata,
  input  wire logic        wr,
  input  wire logic        rd,
  output logic      [15:0] rdata,
  // calendar timebase events, same clock domain
  input  wire logic        day_tick,
  input  wire logic        alarm_event,
  // window data to the alarm value store
  output logic      [1:0]  alarm_window_pointer,
  output logic             alarm_window_access,
  output logic             alarm_window_upper,
  output logic             alarm_window_write,
  input  wire logic [15:0] alarm_value_window,
  // loose control bits toward the rest of the clock
  output logic             clock_value_write_enable,
  output logic             repeat_wrap_enable,
  output logic             alarm_repeats_expired,
  // interrupt
  output logic             irq
);
  localparam int NB = rtcdr_pkg::IRQ_BITS;

  typedef struct packed {
    logic [7:0]    rpt;
    logic [1:0]    ptr;
    logic          wrap;
    logic          wren;
    logic [NB-1:0] ist;
    logic [NB-1:0] ien;
    logic [15:0]   rdata;
    logic          expired;
  } rtcdr_st_t;

  rtcdr_st_t st_r, st_nxt;

  rtcdr_bus_if cb ();

  ////////////////////////////////////////////////////////////////////////
  // calendar digits live in the counter module
  rtcdr_calendar u_cal (
    .clk  (clk),
    .srst (srst),
    .cb   (cb)
  );

  // software load only when write enable is set
  assign cb.day_tick    = day_tick;
  assign cb.sw_wr_year  = wr && addr == rtcdr_pkg::ADDR_YEAR
                          && st_r.wren;
  assign cb.sw_wr_calendar_month_day_value = wr && addr == rtcdr_pkg::ADDR_CALENDAR_MONTH_DAY_VALUE
                          && st_r.wren;
  assign cb.wdata       = wdata;

  ////////////////////////////////////////////////////////////////////////
  // window decode: upper flag is set on any window access while the pointer is not the unimplemented code
  logic win_acc;
  logic win_upper;
  assign win_acc   = (wr || rd) && addr == rtcdr_pkg::ADDR_WIN;
  assign win_upper = win_acc && st_r.ptr != rtcdr_pkg::PTR_UNIMPL;

  // read mux, pure function of address and state
  function automatic logic [15:0] rtcdr_read(input logic [3:0] a,
                                             input rtcdr_st_t s,
                                             input logic [7:0] yr,
                                             input logic [12:0] md,
                                             input logic [15:0] win);
    rtcdr_read = 16'h0000;
    if (a == rtcdr_pkg::ADDR_CTRL) begin
      rtcdr_read = {s.wren, s.wrap, 4'h0, s.ptr, s.rpt};
    end else if (a == rtcdr_pkg::ADDR_YEAR) begin
      rtcdr_read = {8'h00, yr};
    end else if (a == rtcdr_pkg::ADDR_CALENDAR_MONTH_DAY_VALUE) begin
      rtcdr_read = {3'b000, md[12:8], 2'b00, md[5:0]};
    end else if (a == rtcdr_pkg::ADDR_WIN) begin
      rtcdr_read = (s.ptr == rtcdr_pkg::PTR_UNIMPL) ? 16'h0000 : win;
    end else if (a == rtcdr_pkg::ADDR_IRQ_ST) begin
      rtcdr_read = 16'(s.ist);
    end else if (a == rtcdr_pkg::ADDR_IRQ_EN) begin
      rtcdr_read = 16'(s.ien);
    end
  endfunction
  // md bits 7..6 and 15..13 are forced zero above

  ////////////////////////////////////////////////////////////////////////
  // next state
  always_comb begin
    logic [NB-1:0] ev;
    ev = '0;
    st_nxt = st_r;
    st_nxt.expired = 1'b0;
    st_nxt.rdata = rd ? rtcdr_read(addr, st_r, cb.year, cb.calendar_month_day_value,
                                   alarm_value_window) : 16'h0000;

    // control register write
    if (wr && addr == rtcdr_pkg::ADDR_CTRL) begin
      st_nxt.rpt  = wdata[rtcdr_pkg::CTRL_RPT_LSB +: 8];
      st_nxt.ptr  = wdata[rtcdr_pkg::CTRL_PTR_LSB +: 2];
      st_nxt.wrap = wdata[rtcdr_pkg::CTRL_WRAP_BIT];
      st_nxt.wren = wdata[rtcdr_pkg::CTRL_WREN_BIT];
    end else if (win_upper && st_r.ptr != 2'h0) begin
      // pointer steps down after each upper access, stops at zero
      st_nxt.ptr = 2'(st_r.ptr - 2'h1);
    end

    // alarm event counts the repeat down; a decrement beats a same-cycle write
    if (alarm_event) begin
      ev[rtcdr_pkg::IRQ_ALARM_BIT] = 1'b1;
      if (st_r.rpt != 8'h00 || st_r.wrap) begin
        st_nxt.rpt = 8'(st_r.rpt - 8'h01);
      end else begin
        // zero held: no further repeats left
        st_nxt.expired = 1'b1;
        ev[rtcdr_pkg::IRQ_EXPIRE_BIT] = 1'b1;
      end
    end
    ev[rtcdr_pkg::IRQ_YEAR_BIT] = cb.year_roll;

    // interrupt enable and write-one-to-clear; set wins over clear
    if (wr && addr == rtcdr_pkg::ADDR_IRQ_EN) begin
      st_nxt.ien = wdata[NB-1:0];
    end
    if (wr && addr == rtcdr_pkg::ADDR_IRQ_CLR) begin
      st_nxt.ist = st_r.ist & ~wdata[NB-1:0];
    end
    st_nxt.ist = st_nxt.ist | ev;
  end

  // state register
  always_ff @(posedge clk) begin
    if (srst) begin
      st_r <= '{rpt: rtcdr_pkg::RST_RPT, ptr: rtcdr_pkg::RST_PTR,
                wrap: 1'b0, wren: 1'b0, ist: '0, ien: '0,
                rdata: 16'h0000, expired: 1'b0};
    end else begin
      st_r <= st_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // outputs
  assign rdata                    = st_r.rdata;
  assign alarm_window_pointer     = st_r.ptr;
  assign alarm_window_access      = win_acc;
  assign alarm_window_upper       = win_upper;
  assign alarm_window_write       = win_acc && wr;
  assign clock_value_write_enable = st_r.wren;
  assign repeat_wrap_enable       = st_r.wrap;
  assign alarm_repeats_expired    = st_r.expired;
  // level interrupt while any enabled status bit stands
  assign irq = |(st_r.ist & st_r.ien);
endmodule // rtcdr_top

/* File: rtcdr_pkg.sv */
package rtcdr_pkg;
  // register offsets on the plain register port (word index)
  localparam logic [3:0] ADDR_CTRL    = 4'h0;
  localparam logic [3:0] ADDR_YEAR    = 4'h1;
  localparam logic [3:0] ADDR_CALENDAR_MONTH_DAY_VALUE   = 4'h2;
  localparam logic [3:0] ADDR_WIN     = 4'h3;
  localparam logic [3:0] ADDR_IRQ_ST  = 4'h4;
  localparam logic [3:0] ADDR_IRQ_EN  = 4'h5;
  localparam logic [3:0] ADDR_IRQ_CLR = 4'h6;

  // control register fields
  localparam int CTRL_RPT_LSB  = 0;
  localparam int CTRL_PTR_LSB  = 8;
  localparam int CTRL_WRAP_BIT = 14;
  localparam int CTRL_WREN_BIT = 15;

  // year and month/day fields
  localparam int YR_TENS_LSB  = 4;
  localparam int YR_ONES_LSB  = 0;
  localparam int MON_TENS_BIT = 12;
  localparam int MON_ONES_LSB = 8;
  localparam int DAY_TENS_LSB = 4;
  localparam int DAY_ONES_LSB = 0;

  // interrupt status bits
  localparam int IRQ_ALARM_BIT = 0;
  localparam int IRQ_YEAR_BIT  = 1;
  localparam int IRQ_EXPIRE_BIT = 2;
  localparam int IRQ_BITS      = 3;

  // reset values: first of the month, year 00
  localparam logic [7:0]  RST_YEAR  = 8'h00;
  localparam logic [12:0] RST_CALENDAR_MONTH_DAY_VALUE = 13'h0101;
  localparam logic [7:0]  RST_RPT   = 8'h00;
  localparam logic [1:0]  RST_PTR   = 2'h0;
  localparam logic [1:0]  PTR_UNIMPL = 2'h3;
endpackage

/* File: rtcdr_bus_if.sv */
`timescale 1ns/1ps
// calendar tick path between the top and the calendar counter
interface rtcdr_bus_if;
  logic        day_tick;
  logic        sw_wr_year;
  logic        sw_wr_calendar_month_day_value;
  logic [15:0] wdata;
  logic [7:0]  year;
  logic [12:0] calendar_month_day_value;
  logic        year_roll;

  modport top (output day_tick, sw_wr_year, sw_wr_calendar_month_day_value, wdata,
               input year, calendar_month_day_value, year_roll);
  modport cal (input day_tick, sw_wr_year, sw_wr_calendar_month_day_value, wdata,
               output year, calendar_month_day_value, year_roll);
endinterface

/* File: rtcdr_calendar.sv */
`timescale 1ns/1ps
// bcd year and month/day counter; software load or hardware advance
module rtcdr_calendar (
  // clock and reset
  input  wire logic clk,
  input  wire logic srst,
  // link to top
  rtcdr_bus_if.cal  cb
);
  typedef struct packed {
    logic [7:0]  year;
    logic [12:0] calendar_month_day_value;
    logic        roll;
  } rtcdr_cal_st_t;

  rtcdr_cal_st_t st_r, st_nxt;

  // days in month from bcd month, leap from bcd year (2000-2099 range)
  function automatic logic [5:0] rtcdr_last_day(input logic [4:0] m,
                                                 input logic [7:0] y);
    logic [5:0] bin;
    logic leap;
    bin  = 6'(m[4] ? 10 + m[3:0] : m[3:0]);
    leap = ((y[4] ? 4'(y[3:0] + 4'hA) : y[3:0]) & 4'h3) == 4'h0;
    case (bin)
      6'h02:   rtcdr_last_day = leap ? 6'h29 : 6'h28;
      6'h04, 6'h06, 6'h09, 6'h0B: rtcdr_last_day = 6'h30;
      default: rtcdr_last_day = 6'h31;
    endcase
  endfunction

  // one bcd digit step, carry when limit reached
  function automatic logic [3:0] rtcdr_inc(input logic [3:0] d);
    rtcdr_inc = (d == 4'h9) ? 4'h0 : 4'(d + 4'h1);
  endfunction

  // next state
  always_comb begin
    logic [5:0] day;
    logic [4:0] mon;
    day = {cb.calendar_month_day_value[5:4], cb.calendar_month_day_value[3:0]};
    mon = cb.calendar_month_day_value[12:8];
    st_nxt = st_r;
    st_nxt.roll = 1'b0;
    if (cb.sw_wr_year) begin
      st_nxt.year = cb.wdata[7:0];
    end else if (cb.sw_wr_calendar_month_day_value) begin
      st_nxt.calendar_month_day_value = {cb.wdata[12:8], 2'b00, cb.wdata[5:0]};
    end else if (cb.day_tick) begin
      if (day == rtcdr_last_day(mon, st_r.year)) begin
        st_nxt.calendar_month_day_value[5:0] = 6'h01;
        if (mon == 5'h12) begin
          st_nxt.calendar_month_day_value[12:8] = 5'h01;
          st_nxt.roll = 1'b1;
          st_nxt.year[3:0] = rtcdr_inc(st_r.year[3:0]);
          if (st_r.year[3:0] == 4'h9) begin
            st_nxt.year[7:4] = rtcdr_inc(st_r.year[7:4]);
          end
        end else if (mon[3:0] == 4'h9) begin
          st_nxt.calendar_month_day_value[12:8] = 5'h10;
        end else begin
          st_nxt.calendar_month_day_value[11:8] = 4'(mon[3:0] + 4'h1);
        end
      end else if (day[3:0] == 4'h9) begin
        st_nxt.calendar_month_day_value[5:0] = {2'(day[5:4] + 2'h1), 4'h0};
      end else begin
        st_nxt.calendar_month_day_value[3:0] = 4'(day[3:0] + 4'h1);
      end
    end
  end

  // state register
  always_ff @(posedge clk) begin
    if (srst) begin
      st_r <= '{year: rtcdr_pkg::RST_YEAR, calendar_month_day_value: rtcdr_pkg::RST_CALENDAR_MONTH_DAY_VALUE,
                roll: 1'b0};
    end else begin
      st_r <= st_nxt;
    end
  end

  assign cb.year      = st_r.year;
  assign cb.calendar_month_day_value     = st_r.calendar_month_day_value;
  assign cb.year_roll = st_r.roll;
endmodule // rtcdr_calendar

/* File: rtcdr_properties.sv */
`timescale 1ns/1ps
// port-level checks of the date and alarm repeat block
module rtcdr_properties (
  // clock and reset
  input wire logic        clk,
  input wire logic        srst,
  // register port
  input wire logic [3:0]  addr,
  input wire logic [15:0] wdata,
  input wire logic        wr,
  input wire logic        rd,
  input wire logic [15:0] rdata,
  // alarm side
  input wire logic        alarm_event,
  input wire logic [1:0]  alarm_window_pointer,
  input wire logic        alarm_window_access,
  input wire logic        alarm_window_upper,
  input wire logic        alarm_window_write,
  input wire logic        clock_value_write_enable,
  input wire logic        repeat_wrap_enable,
  input wire logic        alarm_repeats_expired,
  input wire logic        irq
);
  default clocking @(posedge clk); endclocking
  default disable iff (srst);
  ////////////////////////////////////////////////////////////////////////////
  // read data only stand in the slot after a read
  rd_slot_a: assert property (!rd |=> rdata == 16'h0000)
    else $error("read data outside the read slot");
  year_hi_a: assert property (rd && addr == rtcdr_pkg::ADDR_YEAR |=>
    rdata[15:8] == 8'h00 && rdata[7:4] <= 4'h9 && rdata[3:0] <= 4'h9)
    else $error("year read has bad upper byte or digit");
  calendar_month_day_value_gap_a: assert property (rd && addr == rtcdr_pkg::ADDR_CALENDAR_MONTH_DAY_VALUE |=>
    rdata[15:13] == 3'h0 && rdata[7:6] == 2'h0 && rdata[11:8] <= 4'h9)
    else $error("month/day read has bad unused bits");
  // pointer steps down by one per access from codes 2 and 1, stops at zero; code 3 does not step
  ptr_step_a: assert property (alarm_window_access &&
    alarm_window_pointer inside {2'h1, 2'h2} |=>
    alarm_window_pointer == $past(alarm_window_pointer) - 2'h1)
    else $error("window pointer did not step down");
  ptr_floor_a: assert property (alarm_window_access &&
    alarm_window_pointer == 2'h0 |=> alarm_window_pointer == 2'h0)
    else $error("window pointer left zero");
  ptr_unimpl_a: assert property (rd && addr == rtcdr_pkg::ADDR_WIN &&
    alarm_window_pointer == 2'h3 |=> rdata == 16'h0000)
    else $error("unimplemented window code read nonzero");
  expire_cause_a: assert property (alarm_repeats_expired |->
    $past(alarm_event) && !$past(repeat_wrap_enable))
    else $error("expiry without an unwrapped alarm");
  // irq is a plain decode of registered state, so it follows at once
  irq_mask_a: assert property (wr && addr == rtcdr_pkg::ADDR_IRQ_EN &&
    wdata[2:0] == 3'h0 |=> !irq)
    else $error("irq high with all sources masked");
  // control write loads the write enable seen by the calendar lock
  wren_load_a: assert property (wr && addr == rtcdr_pkg::ADDR_CTRL |=>
    clock_value_write_enable == $past(wdata[rtcdr_pkg::CTRL_WREN_BIT]))
    else $error("write enable bit not loaded");
  win_write_a: assert property (alarm_window_write ==
    (wr && addr == rtcdr_pkg::ADDR_WIN))
    else $error("window write strobe wrong");
  win_upper_a: assert property (alarm_window_upper ==
    (alarm_window_access && alarm_window_pointer != 2'h3))
    else $error("window upper flag wrong");
  c_expire: cover property (alarm_repeats_expired);
  c_ptr: cover property (alarm_window_access && alarm_window_pointer == 2'h1);
  c_irq: cover property ($rose(irq));
endmodule // rtcdr_properties

bind rtcdr_top rtcdr_properties i_rtcdr_properties (
  .clk(clk), .srst(srst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
  .rdata(rdata), .alarm_event(alarm_event),
  .alarm_window_pointer(alarm_window_pointer),
  .alarm_window_access(alarm_window_access),
  .alarm_window_upper(alarm_window_upper),
  .alarm_window_write(alarm_window_write),
  .clock_value_write_enable(clock_value_write_enable),
  .repeat_wrap_enable(repeat_wrap_enable),
  .alarm_repeats_expired(alarm_repeats_expired), .irq(irq));

/* File: testbench.sv */
`timescale 1ns/1ps
// register-port bench; reads are checked one cycle late
module testbench;
  logic        clk = 1'b0;
  logic        srst = 1'b1;
  logic [3:0]  addr = 4'h0;
  logic [15:0] wdata = 16'h0000;
  logic        wr = 1'b0;
  logic        rd = 1'b0;
  logic        day_tick = 1'b0;
  logic        alarm_event = 1'b0;
  logic [15:0] win = 16'h0000;
  logic [15:0] rdata;
  logic        irq;
  logic        rd_d = 1'b0;
  logic [15:0] exp_q[$];
  int          failures = 0;
  int          check_count = 0;
  int          cyc = 0;
  logic [15:0] v;
  logic [15:0] md [3] = '{16'h1231, 16'h0228, 16'h0228};
  logic [15:0] nx [3] = '{16'h0101, 16'h0301, 16'h0229};
  logic [7:0]  yr [3] = '{8'h99, 8'h01, 8'h04};

  rtcdr_top i_rtcdr_top (.clk(clk), .srst(srst), .addr(addr), .wdata(wdata),
    .wr(wr), .rd(rd), .rdata(rdata), .day_tick(day_tick),
    .alarm_event(alarm_event), .alarm_window_pointer(),
    .alarm_window_access(), .alarm_window_upper(), .alarm_window_write(),
    .alarm_value_window(win), .clock_value_write_enable(),
    .repeat_wrap_enable(), .alarm_repeats_expired(), .irq(irq));

  // 25 MHz
  always #20 clk = ~clk;

  task automatic chk(string n, logic [15:0] e, logic [15:0] g);
    check_count++;
    if (g !== e) begin
      failures++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic w(logic [3:0] a, logic [15:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  task automatic r(logic [3:0] a, logic [15:0] e);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    exp_q.push_back(e);
    @(posedge clk);
    rd <= 1'b0;
  endtask

  task automatic ev(logic t, logic a);
    @(posedge clk);
    day_tick <= t;
    alarm_event <= a;
    @(posedge clk);
    day_tick <= 1'b0;
    alarm_event <= 1'b0;
  endtask

  task automatic final_report();
    $display("checks %0d mismatches %0d", check_count, failures);
    if (failures == 0 && check_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // read data land in the cycle after the strobe, so compare mid-cycle
  always @(posedge clk) rd_d <= rd;
  always @(negedge clk) begin
    if (rd_d) begin
      chk("rdata", exp_q.pop_front(), rdata);
    end
  end

  // hang guard; the run needs well under a thousand cycles
  always @(posedge clk) begin
    cyc++;
    if (cyc == 3000) begin
      failures++;
      final_report();
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    void'($urandom(32'h3ABB0352));
    repeat (12) @(posedge clk);
    srst <= 1'b0;
    r(rtcdr_pkg::ADDR_CTRL, 16'h0000);
    r(rtcdr_pkg::ADDR_CALENDAR_MONTH_DAY_VALUE, 16'h0101);
    r(4'h7, 16'h0000);
    // locked writes are dropped
    w(rtcdr_pkg::ADDR_YEAR, 16'h0042);
    w(rtcdr_pkg::ADDR_CALENDAR_MONTH_DAY_VALUE, 16'h0612);
    r(rtcdr_pkg::ADDR_YEAR, 16'h0000);
    r(rtcdr_pkg::ADDR_CALENDAR_MONTH_DAY_VALUE, 16'h0101);
    w(rtcdr_pkg::ADDR_CTRL, 16'h8000);
    w(rtcdr_pkg::ADDR_CALENDAR_MONTH_DAY_VALUE, 16'hF2F1);
    r(rtcdr_pkg::ADDR_CALENDAR_MONTH_DAY_VALUE, 16'h1231);
    repeat (4) begin
      v = {8'hA5, 4'($urandom % 10), 4'($urandom % 10)};
      w(rtcdr_pkg::ADDR_YEAR, v);
      r(rtcdr_pkg::ADDR_YEAR, {8'h00, v[7:0]});
    end
    $display("test writes done");
    // day advance over year end, plain and leap february
    w(rtcdr_pkg::ADDR_IRQ_CLR, 16'h0007);
    w(rtcdr_pkg::ADDR_IRQ_EN, 16'h0007);
    for (int i = 0; i < 3; i++) begin
      w(rtcdr_pkg::ADDR_YEAR, {8'h00, yr[i]});
      w(rtcdr_pkg::ADDR_CALENDAR_MONTH_DAY_VALUE, md[i]);
      ev(1'b1, 1'b0);
      r(rtcdr_pkg::ADDR_CALENDAR_MONTH_DAY_VALUE, nx[i]);
      r(rtcdr_pkg::ADDR_YEAR, {8'h00, (i == 0) ? 8'h00 : yr[i]});
    end
    r(rtcdr_pkg::ADDR_IRQ_ST, 16'h0002);
    @(negedge clk);
    chk("irq", 16'h0001, {15'h0000, irq});
    w(rtcdr_pkg::ADDR_IRQ_EN, 16'h0000);
    repeat (2) @(negedge clk);
    chk("irq", 16'h0000, {15'h0000, irq});
    w(rtcdr_pkg::ADDR_IRQ_CLR, 16'h0007);
    r(rtcdr_pkg::ADDR_IRQ_ST, 16'h0000);
    $display("test calendar done");
    // repeat count runs down, holds at zero, wraps only when allowed
    w(rtcdr_pkg::ADDR_CTRL, 16'h8002);
    ev(1'b0, 1'b1);
    ev(1'b0, 1'b1);
    r(rtcdr_pkg::ADDR_CTRL, 16'h8000);
    ev(1'b0, 1'b1);
    r(rtcdr_pkg::ADDR_CTRL, 16'h8000);
    r(rtcdr_pkg::ADDR_IRQ_ST, 16'h0005);
    w(rtcdr_pkg::ADDR_CTRL, 16'hC000);
    ev(1'b0, 1'b1);
    r(rtcdr_pkg::ADDR_CTRL, 16'hC0FF);
    ev(1'b0, 1'b1);
    r(rtcdr_pkg::ADDR_CTRL, 16'hC0FE);
    $display("test repeat done");
    // window pointer walks down and stops at zero
    win <= 16'($urandom);
    w(rtcdr_pkg::ADDR_CTRL, 16'h8200);
    for (int p = 2; p >= 0; p--) begin
      r(rtcdr_pkg::ADDR_WIN, win);
      r(rtcdr_pkg::ADDR_CTRL, {6'h20, 2'((p > 0) ? p - 1 : 0), 8'h00});
    end
    // a window write counts as an access and steps the pointer too
    w(rtcdr_pkg::ADDR_CTRL, 16'h8100);
    w(rtcdr_pkg::ADDR_WIN, 16'($urandom));
    r(rtcdr_pkg::ADDR_CTRL, 16'h8000);
    w(rtcdr_pkg::ADDR_CTRL, 16'h8300);
    r(rtcdr_pkg::ADDR_WIN, 16'h0000);
    r(rtcdr_pkg::ADDR_CTRL, 16'h8300);
    $display("test window done");
    // mid-run reset returns control, year, month/day and status registers to their reset values
    @(posedge clk);
    srst <= 1'b1;
    repeat (2) @(posedge clk);
    srst <= 1'b0;
    r(rtcdr_pkg::ADDR_CTRL, 16'h0000);
    r(rtcdr_pkg::ADDR_YEAR, 16'h0000);
    r(rtcdr_pkg::ADDR_CALENDAR_MONTH_DAY_VALUE, 16'h0101);
    r(rtcdr_pkg::ADDR_IRQ_ST, 16'h0000);
    $display("test reset done");
    repeat (3) @(posedge clk);
    final_report();
  end
endmodule // testbench
